// File: verilog/dpp_pkg.sv
/*
 * dpp_pkg: register map, field positions, mode encodings and carriers
 * for the dual parallel interface block.
 * assumes: one pclk domain, APB slave with 32-bit data.
 */
package dpp_pkg;

    // ****************************************************************
    // register map (byte addresses), 8 word slots per unit
    // ****************************************************************
    localparam int dpp_unit_count = 2;
    localparam int dpp_slot_count = 8;
    localparam logic [11:0] dpp_unit_stride = 12'h020;
    localparam logic [11:0] dpp_unit_span = 12'h040;
    localparam logic [2:0] dpp_reg_first = 3'h0;
    localparam logic [2:0] dpp_reg_second = 3'h1;
    localparam logic [2:0] dpp_reg_control = 3'h2;
    localparam logic [2:0] dpp_reg_command = 3'h3;
    localparam logic [2:0] dpp_reg_status = 3'h4;

    // ****************************************************************
    // command word fields
    // ****************************************************************
    localparam int dpp_cmd_mode_flag = 7;
    localparam int dpp_cmd_hi_mode_msb = 6;
    localparam int dpp_cmd_hi_mode_lsb = 5;
    localparam int dpp_cmd_first_dir = 4;
    localparam int dpp_cmd_ctl_hi_dir = 3;
    localparam int dpp_cmd_lo_mode = 2;
    localparam int dpp_cmd_second_dir = 1;
    localparam int dpp_cmd_ctl_lo_dir = 0;
    localparam int dpp_bsr_bit_msb = 3;
    localparam int dpp_bsr_bit_lsb = 1;
    localparam int dpp_bsr_value = 0;
    localparam logic [7:0] dpp_cmd_reset = 8'h9B;

    // ****************************************************************
    // control port line roles in strobed and bidirectional modes
    // ****************************************************************
    localparam int dpp_lo_irq = 0;
    localparam int dpp_lo_ack = 1;
    localparam int dpp_lo_stb = 2;
    localparam int dpp_hi_irq = 3;
    localparam int dpp_hi_in_stb = 4;
    localparam int dpp_hi_in_full = 5;
    localparam int dpp_hi_out_ack = 6;
    localparam int dpp_hi_out_full = 7;
    localparam int dpp_status_width = 8;

    typedef enum logic [1:0] {
        dpp_mode_simple = 2'h0,
        dpp_mode_strobed = 2'h1,
        dpp_mode_bidir = 2'h2
    } dpp_mode_type;

    typedef struct packed {
        logic [7:0] first_in;
        logic [7:0] second_in;
        logic [7:0] control_in;
    } dpp_pins_in_type;

    typedef struct packed {
        logic [7:0] first_out;
        logic [7:0] first_oe;
        logic [7:0] second_out;
        logic [7:0] second_oe;
        logic [7:0] control_out;
        logic [7:0] control_oe;
    } dpp_pins_out_type;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [2:0] slot;
        logic [7:0] wdata;
    } dpp_access_type;

endpackage : dpp_pkg

// File: verilog/dpp_unit.sv
/*
 * dpp_unit: one programmable parallel interface unit of 24 lines.
 * assumes: access pulses are one cycle, pins synchronous to pclk.
 */
`timescale 1ns/100ps
module dpp_unit
    import dpp_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire dpp_access_type acc,
    output logic [7:0] rdata,
    input wire dpp_pins_in_type pin_in,
    output dpp_pins_out_type pin_out,
    output logic irq
);

    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        dpp_mode_type hi_mode;
        logic lo_strobed;
        logic first_in_dir;
        logic second_in_dir;
        logic ctl_hi_in_dir;
        logic ctl_lo_in_dir;
        logic [7:0] first_latch;
        logic [7:0] first_in_latch;
        logic [7:0] second_latch;
        logic [7:0] control_latch;
        logic [7:0] rdata;
        logic [7:0] ctl_prev;
    } dpp_unit_state_type;

    dpp_unit_state_type st;
    dpp_unit_state_type next_st;

    logic [7:0] ctl_view;
    logic [7:0] first_oe;
    logic [7:0] second_oe;
    logic [7:0] ctl_oe;
    logic [7:0] ctl_drive;
    logic [7:0] ctl_fall;
    logic [7:0] ctl_rise;
    logic [2:0] bit_sel;

    assign ctl_fall = st.ctl_prev & ~pin_in.control_in;
    assign ctl_rise = ~st.ctl_prev & pin_in.control_in;
    assign bit_sel = acc.wdata[dpp_bsr_bit_msb:dpp_bsr_bit_lsb];

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        next_st = st;
        next_st.ctl_prev = pin_in.control_in;
        // reads release the buffer first, so a strobe in the same cycle wins
        if (acc.rd && acc.slot == dpp_reg_first &&
            st.hi_mode != dpp_mode_simple) begin
            next_st.control_latch[dpp_hi_in_full] = 1'b0;
            next_st.control_latch[dpp_hi_irq] = 1'b0;
        end
        if (acc.rd && acc.slot == dpp_reg_second && st.lo_strobed &&
            st.second_in_dir) begin
            next_st.control_latch[dpp_lo_ack] = 1'b0;
            next_st.control_latch[dpp_lo_irq] = 1'b0;
        end
        // handshake: input strobe latches data and sets buffer full
        if (st.lo_strobed && st.second_in_dir && ctl_fall[dpp_lo_stb]) begin
            next_st.second_latch = pin_in.second_in;
            next_st.control_latch[dpp_lo_ack] = 1'b1;
            next_st.control_latch[dpp_lo_irq] = 1'b1;
        end
        if (st.lo_strobed && !st.second_in_dir && ctl_fall[dpp_lo_ack]) begin
            next_st.control_latch[dpp_lo_stb] = 1'b1;
        end
        if (st.lo_strobed && !st.second_in_dir && ctl_rise[dpp_lo_ack]) begin
            next_st.control_latch[dpp_lo_irq] = 1'b1;
        end
        if (st.hi_mode != dpp_mode_simple) begin
            if ((st.first_in_dir || st.hi_mode == dpp_mode_bidir) &&
                ctl_fall[dpp_hi_in_stb]) begin
                next_st.first_in_latch = pin_in.first_in;
                next_st.control_latch[dpp_hi_in_full] = 1'b1;
                next_st.control_latch[dpp_hi_irq] = 1'b1;
            end
            if ((!st.first_in_dir || st.hi_mode == dpp_mode_bidir) &&
                ctl_fall[dpp_hi_out_ack]) begin
                next_st.control_latch[dpp_hi_out_full] = 1'b1;
            end
            if ((!st.first_in_dir || st.hi_mode == dpp_mode_bidir) &&
                ctl_rise[dpp_hi_out_ack]) begin
                next_st.control_latch[dpp_hi_irq] = 1'b1;
            end
        end
        if (acc.wr) begin
            unique case (acc.slot)
                dpp_reg_first: begin
                    next_st.first_latch = acc.wdata;
                    if (st.hi_mode != dpp_mode_simple) begin
                        // low-active full flag, then irq drops
                        next_st.control_latch[dpp_hi_out_full] = 1'b0;
                        next_st.control_latch[dpp_hi_irq] = 1'b0;
                    end
                end
                dpp_reg_second: begin
                    next_st.second_latch = acc.wdata;
                    if (st.lo_strobed) begin
                        // strobe line doubles as full flag here
                        next_st.control_latch[dpp_lo_stb] = 1'b0;
                        next_st.control_latch[dpp_lo_irq] = 1'b0;
                    end
                end
                dpp_reg_control: next_st.control_latch = acc.wdata;
                dpp_reg_command: begin
                    if (acc.wdata[dpp_cmd_mode_flag]) begin
                        // mode word: applies now, clears latches
                        next_st.hi_mode = dpp_mode_type'(acc.wdata[
                            dpp_cmd_hi_mode_msb:dpp_cmd_hi_mode_lsb]);
                        if (acc.wdata[dpp_cmd_hi_mode_msb])
                            next_st.hi_mode = dpp_mode_bidir;
                        next_st.lo_strobed = acc.wdata[dpp_cmd_lo_mode];
                        next_st.first_in_dir = acc.wdata[dpp_cmd_first_dir];
                        next_st.second_in_dir = acc.wdata[dpp_cmd_second_dir];
                        next_st.ctl_hi_in_dir = acc.wdata[dpp_cmd_ctl_hi_dir];
                        next_st.ctl_lo_in_dir = acc.wdata[dpp_cmd_ctl_lo_dir];
                        next_st.first_latch = 8'h00;
                        next_st.first_in_latch = 8'h00;
                        next_st.second_latch = 8'h00;
                        next_st.control_latch = 8'h00;
                    end else begin
                        // single-bit set/clear of control port
                        next_st.control_latch[bit_sel] =
                            acc.wdata[dpp_bsr_value];
                    end
                end
                default: ;
            endcase
        end
        if (acc.rd) begin
            unique case (acc.slot)
                dpp_reg_first: next_st.rdata =
                    (st.hi_mode != dpp_mode_simple) ? st.first_in_latch :
                    (st.first_in_dir ? pin_in.first_in : st.first_latch);
                dpp_reg_second: next_st.rdata =
                    (st.lo_strobed && st.second_in_dir) ? st.second_latch :
                    (st.second_in_dir ? pin_in.second_in : st.second_latch);
                dpp_reg_control: next_st.rdata = ctl_view;
                dpp_reg_command: next_st.rdata = {1'b1, st.hi_mode,
                    st.first_in_dir, st.ctl_hi_in_dir, st.lo_strobed,
                    st.second_in_dir, st.ctl_lo_in_dir};
                dpp_reg_status: next_st.rdata = st.control_latch;
                default: next_st.rdata = 8'h00;
            endcase
        end
    end

    // ****************************************************************
    // pin direction by mode
    // ****************************************************************
    always_comb begin
        // simple mode: sets of 4 control lines follow their own bit
        ctl_oe = {{4{~st.ctl_hi_in_dir}}, {4{~st.ctl_lo_in_dir}}};
        ctl_drive = st.control_latch;
        if (st.lo_strobed) begin
            // three handshake lines taken from the low set
            ctl_oe[dpp_lo_irq] = 1'b1;
            ctl_oe[dpp_lo_ack] = st.second_in_dir;
            ctl_oe[dpp_lo_stb] = ~st.second_in_dir;
        end
        if (st.hi_mode == dpp_mode_strobed) begin
            ctl_oe[dpp_hi_irq] = 1'b1;
            ctl_oe[dpp_hi_in_stb] = 1'b0;
            ctl_oe[dpp_hi_in_full] = st.first_in_dir;
            ctl_oe[dpp_hi_out_ack] = 1'b0;
            ctl_oe[dpp_hi_out_full] = ~st.first_in_dir;
        end else if (st.hi_mode == dpp_mode_bidir) begin
            // five lines, irq borrowed from the low set
            ctl_oe[7:3] = 5'b10101;
        end
        ctl_view = (ctl_oe & st.control_latch) |
                   (~ctl_oe & pin_in.control_in);
        // whole-byte direction in simple and strobed modes
        first_oe = {8{~st.first_in_dir}};
        if (st.hi_mode == dpp_mode_bidir) begin
            // drive only while the partner acknowledges
            first_oe = {8{~pin_in.control_in[dpp_hi_out_ack]}};
        end
        second_oe = {8{~st.second_in_dir}};
    end

    assign pin_out = '{first_out: st.first_latch, first_oe: first_oe,
                       second_out: st.second_latch, second_oe: second_oe,
                       control_out: ctl_drive, control_oe: ctl_oe};
    assign rdata = st.rdata;
    // in simple mode line 0 is a plain output, not a request
    assign irq = (st.lo_strobed && st.control_latch[dpp_lo_irq]) |
                 (st.hi_mode != dpp_mode_simple &&
                  st.control_latch[dpp_hi_irq]);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '{hi_mode: dpp_mode_simple, lo_strobed: 1'b0,
                    first_in_dir: 1'b1, second_in_dir: 1'b1,
                    ctl_hi_in_dir: 1'b1, ctl_lo_in_dir: 1'b1,
                    ctl_prev: 8'hFF, default: '0};
        end else begin
            st <= next_st;
        end
    end

endmodule : dpp_unit

// File: verilog/dpp_apb.sv
/*
 * dpp_apb: APB slave front end, turns transfers into access pulses.
 * assumes: APB3 master, zero wait states.
 */
`timescale 1ns/100ps
module dpp_apb
    import dpp_pkg::*;
(
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [dpp_unit_count*8-1:0] unit_rdata,
    output logic [31:0] prdata,
    output logic pslverr,
    output logic [dpp_unit_count-1:0] unit_sel,
    output dpp_access_type acc
);

    logic in_map;
    logic hit;

    // upper unit block decoded separately from the lower one
    assign in_map = paddr < dpp_unit_span && paddr[1:0] == 2'h0;
    assign hit = psel && penable && in_map;
    assign unit_sel = hit ? (paddr[5] ? 2'b10 : 2'b01) : 2'b00;
    assign acc = '{wr: hit && pwrite, rd: hit && !pwrite,
                   slot: paddr[4:2], wdata: pwdata[7:0]};
    assign pslverr = psel && penable && !in_map;
    // units hold read data from the access edge on
    assign prdata = {24'h000000, paddr[5] ? unit_rdata[15:8]
                                          : unit_rdata[7:0]};

endmodule : dpp_apb

// File: verilog/dpp_top.sv
/*
 * dpp_top: dual parallel interface, two independent 24-line units.
 * assumes: APB master on pclk; pins synchronous to pclk.
 */
`timescale 1ns/100ps
module dpp_top
    import dpp_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire dpp_pins_in_type [dpp_unit_count-1:0] pins_in,
    output dpp_pins_out_type [dpp_unit_count-1:0] pins_out,
    output logic [dpp_unit_count-1:0] irq
);

    logic [dpp_unit_count-1:0] unit_sel;
    logic [dpp_unit_count*8-1:0] unit_rdata;
    dpp_access_type acc;

    assign pready = 1'b1;

    dpp_apb u_apb (
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .unit_rdata(unit_rdata),
        .prdata(),
        .pslverr(pslverr),
        .unit_sel(unit_sel),
        .acc(acc)
    );

    // read data is registered at the setup edge, so answer from the address latched then
    logic [11:0] last_addr;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_addr <= 12'h000;
        end else if (psel && !penable) begin
            last_addr <= paddr;
        end
    end
    // ****************************************************************
    // units, each fully separate
    // ****************************************************************
    genvar gi;
    generate
        for (gi = 0; gi < dpp_unit_count; gi++) begin : g_unit
            dpp_access_type uacc;
            always_comb begin
                uacc = acc;
                uacc.wr = acc.wr && unit_sel[gi];
                // refused addresses must not release any buffer
                uacc.rd = psel && !penable && !pwrite &&
                          paddr < dpp_unit_span && paddr[1:0] == 2'h0 &&
                          paddr[5] == 1'(gi);
                uacc.slot = paddr[4:2];
            end
            dpp_unit u_unit (
                .pclk(pclk),
                .presetn(presetn),
                .acc(uacc),
                .rdata(unit_rdata[gi*8 +: 8]),
                .pin_in(pins_in[gi]),
                .pin_out(pins_out[gi]),
                .irq(irq[gi])
            );
        end
    endgenerate

    assign prdata = {24'h000000, last_addr[5] ? unit_rdata[15:8]
                                              : unit_rdata[7:0]};

endmodule : dpp_top

// File: bench/dpp_top_chk.sv
/* dpp_top_chk: bus and line checks on the dual parallel block.
 * assumes: bound into dpp_top, single pclk domain. */
`timescale 1ns/100ps
module dpp_top_chk
    import dpp_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire dpp_pins_in_type [dpp_unit_count-1:0] pins_in,
    input wire dpp_pins_out_type [dpp_unit_count-1:0] pins_out,
    input wire logic [dpp_unit_count-1:0] irq
);
    dpp_pins_out_type o0;
    logic acc;
    logic cw;
    logic mw;
    logic simple;
    assign o0 = pins_out[0];
    assign acc = psel && penable;
    assign cw = acc && pwrite && paddr == 12'h00C;
    assign mw = cw && pwdata[7];
    // bit writes are checked on the lines only while both groups are simple
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            simple <= 1'b1;
        end else if (mw) begin
            simple <= pwdata[6:5] == 2'h0 && !pwdata[2];
        end
    end
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    property p_err;
        acc && (paddr >= 12'h040 || paddr[1:0] != 2'h0) |-> pslverr;
    endproperty
    a_err: assert property (p_err) else $error("no slave error");
    property p_ok;
        acc && paddr < 12'h040 && paddr[1:0] == 2'h0
            |-> pready && !pslverr && prdata[31:8] == 24'h0;
    endproperty
    a_ok: assert property (p_ok) else $error("bad mapped access");
    property p_dir;
        mw && pwdata[6:5] == 2'h0 && !pwdata[2] |=>
            o0.first_oe == {8{!$past(pwdata[4])}}
            && o0.second_oe == {8{!$past(pwdata[1])}}
            && o0.control_oe[7:4] == {4{!$past(pwdata[3])}}
            && o0.control_oe[3:0] == {4{!$past(pwdata[0])}};
    endproperty
    a_dir: assert property (p_dir) else $error("line direction");
    property p_strobed;
        mw && pwdata[6:5] == 2'h1 |=> o0.first_oe == {8{!$past(pwdata[4])}};
    endproperty
    a_strobed: assert property (p_strobed) else $error("byte dir");
    property p_bidir;
        mw && pwdata[6] && pins_in[0].control_in[6] |=> o0.first_oe == 8'h00;
    endproperty
    a_bidir: assert property (p_bidir) else $error("bus driven");
    property p_bit;
        cw && !pwdata[7] && simple
            |=> o0.control_out[$past(pwdata[3:1])] == $past(pwdata[0]);
    endproperty
    a_bit: assert property (p_bit) else $error("bit write");
    property p_clear;
        mw |=> o0.first_out == 8'h00 && o0.second_out == 8'h00 && !irq[0];
    endproperty
    a_clear: assert property (p_clear) else $error("not cleared");
    property p_indep;
        acc && pwrite && paddr < 12'h020 && $stable(pins_in[1])
            |=> $stable(pins_out[1]) && $stable(irq[1]);
    endproperty
    a_indep: assert property (p_indep) else $error("unit 1 moved");
endmodule : dpp_top_chk
bind dpp_top dpp_top_chk dpp_top_chk_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pins_in(pins_in), .pins_out(pins_out), .irq(irq));

// File: bench/dpp_pin_model.sv
/* dpp_pin_model: far-side lines of both units with their pull-ups.
 * assumes: bench gives per-line override levels and enables. */
`timescale 1ns/100ps
module dpp_pin_model
    import dpp_pkg::*;
(
    input wire dpp_pins_out_type [dpp_unit_count-1:0] pins_out,
    input wire dpp_pins_in_type [dpp_unit_count-1:0] ext_val,
    input wire dpp_pins_in_type [dpp_unit_count-1:0] ext_en,
    output dpp_pins_in_type [dpp_unit_count-1:0] pins_in
);
    // an undriven line floats up to its pull-up, it never keeps a value
    function automatic logic [23:0] level(input logic [23:0] o, oe, v, en);
        return (o & oe) | (v & en & ~oe) | ~(oe | en);
    endfunction : level
    always_comb begin
        for (int u = 0; u < dpp_unit_count; u++) begin
            pins_in[u] = level({pins_out[u].first_out,
                pins_out[u].second_out, pins_out[u].control_out},
                {pins_out[u].first_oe, pins_out[u].second_oe,
                pins_out[u].control_oe}, ext_val[u], ext_en[u]);
        end
    end
endmodule : dpp_pin_model

// File: bench/dual_ppi_parallel_io_tb_top.sv
/* dual_ppi_parallel_io_tb_top: self-checking bench for dpp_top.
 * assumes: dpp_pin_model on the lines, bench is the APB master. */
`timescale 1ns/100ps
module dual_ppi_parallel_io_tb_top;
    import dpp_pkg::*;
    logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
    logic pwrite = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, err;
    logic [7:0] rd;
    logic [dpp_unit_count-1:0] irq;
    dpp_pins_in_type [dpp_unit_count-1:0] pi, xv = '0, xe = '0;
    dpp_pins_out_type [dpp_unit_count-1:0] po;
    int fail_count = 0, checked = 0, cycles = 0;
    dpp_top dpp_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins_in(pi),
        .pins_out(po), .irq(irq));
    dpp_pin_model dpp_pin_model_i (.pins_out(po), .ext_val(xv),
        .ext_en(xe), .pins_in(pi));
    initial begin
        forever #4 pclk = ~pclk;
    end
    // whole run needs well under a thousand cycles
    always @(posedge pclk) if (++cycles == 3000) begin
        fail_count++;
        tally_and_finish();
    end
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk(input string n, input logic [7:0] g, e);
        checked++;
        if (g !== e) begin
            $display("MISMATCH %s expected %h seen %h", n, e, g);
            fail_count++;
        end
    endtask : chk
    // ends half a cycle on, so registered results have landed
    task automatic apb(input logic w, input logic [11:0] a,
            input logic [7:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'h2, w, a, 24'h0, d};
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        {rd, err} = {prdata[7:0], pslverr};
        {psel, penable} <= 2'h0;
        @(negedge pclk);
    endtask : apb
    task automatic t_reset();
        chk("oe", po[0].first_oe | po[1].control_oe, 8'h00);
        chk("irq", {6'h0, irq}, 8'h00);
        apb(0, 12'h020, 8'h00);
        chk("pulled", rd, 8'hFF);
        apb(0, 12'h040, 8'h00);
        chk("unmapped", {7'h0, err}, 8'h01);
        $display("reset test done");
    endtask : t_reset
    task automatic t_dirs();
        logic [3:0] i;
        for (int k = 0; k < 16; k++) begin
            i = 4'(k);
            apb(1, 12'h00C, {3'h4, i[3:2], 1'h0, i[1:0]});
            chk("f_oe", po[0].first_oe, {8{!i[3]}});
            chk("c_oe", po[0].control_oe, {{4{!i[2]}}, {4{!i[0]}}});
            chk("s_oe", po[0].second_oe, {8{!i[1]}});
        end
        $display("direction test done");
    endtask : t_dirs
    task automatic t_data();
        apb(1, 12'h00C, 8'h80);
        apb(1, 12'h000, 8'hA5);
        apb(1, 12'h02C, 8'h80);
        apb(1, 12'h020, 8'h11);
        chk("f_out", po[0].first_out, 8'hA5);
        for (int b = 0; b < 8; b++) begin
            apb(1, 12'h00C, {4'h0, 3'(b), 1'h1});
            chk("bit_set", po[0].control_out, 8'h01 << b);
            apb(1, 12'h00C, {4'h0, 3'(b), 1'h0});
            chk("bit_clr", po[0].control_out, 8'h00);
        end
        apb(1, 12'h00C, 8'h80);
        chk("cleared", po[0].first_out, 8'h00);
        chk("u1_kept", po[1].first_out, 8'h11);
        apb(1, 12'h00C, 8'h84);
        apb(1, 12'h004, 8'h3C);
        chk("printer", po[0].second_out & po[0].second_oe, 8'h3C);
        $display("data test done");
    endtask : t_data
    task automatic t_strobed();
        apb(1, 12'h00C, 8'hB0);
        apb(1, 12'h00C, 8'h09);
        @(posedge pclk);
        xv[0] <= '{8'hC3, 8'h00, 8'h00};
        xe[0] <= '{8'hFF, 8'h00, 8'h10};
        repeat (2) @(posedge pclk);
        xv[0].control_in <= 8'h10;
        repeat (8) if (irq[0] !== 1'h1) @(negedge pclk);
        chk("irq", {7'h0, irq[0]}, 8'h01);
        chk("full", po[0].control_out & 8'h20, 8'h20);
        @(posedge pclk);
        xv[0].first_in <= 8'h3C;
        apb(0, 12'h000, 8'h00);
        chk("latched", rd, 8'hC3);
        $display("strobed test done");
    endtask : t_strobed
    task automatic t_bidir();
        @(posedge pclk);
        xe[0] <= '0;
        apb(1, 12'h00C, 8'hC0);
        chk("bus_free", po[0].first_oe, 8'h00);
        apb(1, 12'h000, 8'h5A);
        @(posedge pclk);
        xe[0] <= '{8'h00, 8'h00, 8'h40};
        repeat (8) if (po[0].first_oe !== 8'hFF) @(negedge pclk);
        chk("bus_oe", po[0].first_oe, 8'hFF);
        chk("bus_out", po[0].first_out, 8'h5A);
        $display("bidirectional test done");
    endtask : t_bidir
    task automatic t_low();
        apb(1, 12'h02C, 8'h86);
        @(posedge pclk);
        xv[1] <= '{8'h00, 8'h96, 8'h00};
        xe[1] <= '{8'h00, 8'hFF, 8'h04};
        repeat (3) @(posedge pclk);
        chk("irq1", {7'h0, irq[1]}, 8'h01);
        apb(0, 12'h030, 8'h00);
        chk("status", rd, 8'h03);
        apb(0, 12'h024, 8'h00);
        chk("low_latch", rd, 8'h96);
        chk("irq1_off", {7'h0, irq[1]}, 8'h00);
        $display("low strobed test done");
    endtask : t_low
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'h1;
        t_reset();
        t_dirs();
        t_data();
        t_strobed();
        t_bidir();
        t_low();
        tally_and_finish();
    end
endmodule : dual_ppi_parallel_io_tb_top
